//--- rtl/d8rt_pkg.sv
package d8rt_pkg;

  // ==========================================================================
  // Geometry
  localparam int unsigned NUM_TIMERS = 2;
  localparam int unsigned CNT_W      = 8;
  localparam int unsigned PSC_SEL_W  = 3;
  localparam int unsigned PSC_CNT_W  = 7;
  localparam int unsigned DIV_W      = 2;
  localparam int unsigned IDX_W      = 3;

  // ==========================================================================
  // Timing
  localparam logic [DIV_W-1:0] DIV4_LAST = 2'h3;
  localparam logic [CNT_W-1:0] CNT_FULL  = 8'hff;

  // ==========================================================================
  // Register word indices, byte address is index * 4
  localparam logic [IDX_W-1:0] IDX_COUNT0 = 3'h0;
  localparam logic [IDX_W-1:0] IDX_COUNT1 = 3'h1;
  localparam logic [IDX_W-1:0] IDX_CTRL0  = 3'h2;
  localparam logic [IDX_W-1:0] IDX_CTRL1  = 3'h3;
  localparam logic [IDX_W-1:0] IDX_STATUS = 3'h4;
  localparam logic [IDX_W-1:0] IDX_CLEAR  = 3'h5;
  localparam logic [IDX_W-1:0] IDX_ENABLE = 3'h6;
  localparam int unsigned      IDX_LSB    = 2;

  // ==========================================================================
  // Reset values
  localparam logic [CNT_W-1:0]      COUNT_RST  = 8'h00;
  localparam logic [CNT_W-1:0]      CTRL_RST   = 8'h00;
  localparam logic [NUM_TIMERS-1:0] IRQ_RST    = 2'h0;
  localparam logic [PSC_CNT_W-1:0]  PSC_RST    = 7'h00;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Timer control register layout
  typedef struct packed {
    logic                 mode_hi;
    logic                 mode_lo;
    logic                 spare5;
    logic                 run;
    logic                 spare3;
    logic [PSC_SEL_W-1:0] psc;
  } d8rt_ctrl_s;

  // Buffered write request
  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic             mapped;
    logic [31:0]      data;
    logic [3:0]       strb;
  } d8rt_wreq_s;

endpackage

//--- rtl/d8rt_top.sv
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module d8rt_top #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                            i_clk,
  input  wire logic                            i_resetn,
  input  wire logic                            i_ce,
  input  wire logic [ADDR_W-1:0]               i_s_axi_awaddr,
  input  wire logic                            i_s_axi_awvalid,
  output logic                                 o_s_axi_awready,
  input  wire logic [31:0]                     i_s_axi_wdata,
  input  wire logic [3:0]                      i_s_axi_wstrb,
  input  wire logic                            i_s_axi_wvalid,
  output logic                                 o_s_axi_wready,
  output logic [1:0]                           o_s_axi_bresp,
  output logic                                 o_s_axi_bvalid,
  input  wire logic                            i_s_axi_bready,
  input  wire logic [ADDR_W-1:0]               i_s_axi_araddr,
  input  wire logic                            i_s_axi_arvalid,
  output logic                                 o_s_axi_arready,
  output logic [31:0]                          o_s_axi_rdata,
  output logic [1:0]                           o_s_axi_rresp,
  output logic                                 o_s_axi_rvalid,
  input  wire logic                            i_s_axi_rready,
  input  wire logic [d8rt_pkg::NUM_TIMERS-1:0] i_irq_ack,
  output logic                                 o_irq
);

  localparam int unsigned NT = d8rt_pkg::NUM_TIMERS;
  localparam int unsigned CW = d8rt_pkg::CNT_W;

  // ==========================================================================
  // Declarations
  logic                       awready_ff;
  logic                       wready_ff;
  logic                       bvalid_ff;
  logic [1:0]                 bresp_ff;
  logic                       aw_held_ff;
  logic                       w_held_ff;
  d8rt_pkg::d8rt_wreq_s       wreq_ff;
  logic                       arready_ff;
  logic                       rvalid_ff;
  logic [1:0]                 rresp_ff;
  logic [31:0]                rdata_ff;
  logic [d8rt_pkg::DIV_W-1:0] div_ff;
  logic [NT-1:0]              status_ff;
  logic [NT-1:0]              enable_ff;
  logic                       irq_ff;

  logic                       wr_fire;
  logic                       ar_fire;
  logic [d8rt_pkg::IDX_W-1:0] ar_idx;
  logic                       ar_mapped;
  logic                       tick4;
  logic [NT-1:0]              read_hold;
  logic [NT-1:0]              ovf;
  logic [NT-1:0]              clr_bits;
  logic [NT-1:0]              nxt_status;
  logic [NT*CW-1:0]           cnt_vec;
  logic [NT*CW-1:0]           ctl_vec;
  logic [31:0]                nxt_rdata;
  logic [1:0]                 nxt_rresp;

  // ==========================================================================
  // Write channel
  // Address and data may come in either order; each is held until the
  // response is taken, so only one write is ever outstanding.
  assign wr_fire = i_ce && aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= d8rt_pkg::RESP_OKAY;
      wreq_ff    <= '0;
    end
    else if (i_ce)
    begin
      if (i_s_axi_awvalid && awready_ff)
      begin
        aw_held_ff     <= 1'b1;
        awready_ff     <= 1'b0;
        wreq_ff.idx    <= i_s_axi_awaddr[d8rt_pkg::IDX_LSB +: d8rt_pkg::IDX_W];
        wreq_ff.mapped <= (i_s_axi_awaddr >> (d8rt_pkg::IDX_LSB + d8rt_pkg::IDX_W)) == '0;
      end
      if (i_s_axi_wvalid && wready_ff)
      begin
        w_held_ff    <= 1'b1;
        wready_ff    <= 1'b0;
        wreq_ff.data <= i_s_axi_wdata;
        wreq_ff.strb <= i_s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= (wreq_ff.mapped && wreq_ff.idx <= d8rt_pkg::IDX_ENABLE)
                      ? d8rt_pkg::RESP_OKAY : d8rt_pkg::RESP_SLVERR;
      end
      if (bvalid_ff && i_s_axi_bready)
      begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Read channel
  assign ar_fire   = i_ce && i_s_axi_arvalid && arready_ff;
  assign ar_idx    = i_s_axi_araddr[d8rt_pkg::IDX_LSB +: d8rt_pkg::IDX_W];
  assign ar_mapped = (i_s_axi_araddr >> (d8rt_pkg::IDX_LSB + d8rt_pkg::IDX_W)) == '0;

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = d8rt_pkg::RESP_OKAY;
    if (!ar_mapped)
    begin
      nxt_rresp = d8rt_pkg::RESP_SLVERR;
    end
    else
    begin
      case (ar_idx)
        d8rt_pkg::IDX_COUNT0: nxt_rdata[CW-1:0] = cnt_vec[0 +: CW];
        d8rt_pkg::IDX_COUNT1: nxt_rdata[CW-1:0] = cnt_vec[CW +: CW];
        d8rt_pkg::IDX_CTRL0:  nxt_rdata[CW-1:0] = ctl_vec[0 +: CW];
        d8rt_pkg::IDX_CTRL1:  nxt_rdata[CW-1:0] = ctl_vec[CW +: CW];
        d8rt_pkg::IDX_STATUS: nxt_rdata[NT-1:0] = status_ff;
        d8rt_pkg::IDX_CLEAR:  nxt_rdata         = 32'h0000_0000;
        d8rt_pkg::IDX_ENABLE: nxt_rdata[NT-1:0] = enable_ff;
        default:              nxt_rresp         = d8rt_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= d8rt_pkg::RESP_OKAY;
      rdata_ff   <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      if (ar_fire)
      begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= nxt_rdata;
        rresp_ff   <= nxt_rresp;
      end
      else if (rvalid_ff && i_s_axi_rready)
      begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Common divide-by-four stage
  // Divide by four
  assign tick4 = i_ce && (div_ff == d8rt_pkg::DIV4_LAST);

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      div_ff <= '0;
    end
    else if (i_ce)
    begin
      div_ff <= div_ff + 2'h1;
    end
  end

  // ==========================================================================
  // Timers
  // One counter per timer
  for (genvar gi = 0; gi < NT; gi++)
  begin : g_tmr
    logic [CW-1:0]                  cnt_ff;
    logic [CW-1:0]                  preload_ff;
    d8rt_pkg::d8rt_ctrl_s           ctl_ff;
    logic [d8rt_pkg::PSC_CNT_W-1:0] psc_ff;
    logic [d8rt_pkg::PSC_CNT_W:0]   mask;
    logic                           wr_cnt;
    logic                           wr_ctl;
    logic                           tick;

    assign wr_cnt = wr_fire && wreq_ff.mapped && wreq_ff.strb[0]
                    && (wreq_ff.idx == d8rt_pkg::IDX_COUNT0 + d8rt_pkg::IDX_W'(gi));
    assign wr_ctl = wr_fire && wreq_ff.mapped && wreq_ff.strb[0]
                    && (wreq_ff.idx == d8rt_pkg::IDX_CTRL0 + d8rt_pkg::IDX_W'(gi));

    assign read_hold[gi] = ar_fire && ar_mapped
                           && (ar_idx == d8rt_pkg::IDX_COUNT0 + d8rt_pkg::IDX_W'(gi));

    assign mask = (8'h01 << ctl_ff.psc) - 8'h01;

    assign tick = ctl_ff.run && tick4 && !read_hold[gi]
                  && ((psc_ff & mask[d8rt_pkg::PSC_CNT_W-1:0])
                      == mask[d8rt_pkg::PSC_CNT_W-1:0]);

    assign ovf[gi] = tick && (cnt_ff == d8rt_pkg::CNT_FULL);

    // Bits 7:6 are stored as written; mode is fixed in hardware
    // Run bit stored
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
      begin
        ctl_ff <= d8rt_pkg::CTRL_RST;
      end
      else if (i_ce && wr_ctl)
      begin
        ctl_ff <= wreq_ff.data[CW-1:0];
      end
    end

    // Restart from zero when stopped, so ratio is exact from run
    // Prescaler gated
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
      begin
        psc_ff <= d8rt_pkg::PSC_RST;
      end
      else if (i_ce)
      begin
        if (!ctl_ff.run)
        begin
          psc_ff <= d8rt_pkg::PSC_RST;
        end
        else if (tick4)
        begin
          psc_ff <= psc_ff + 7'h01;
        end
      end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
      begin
        preload_ff <= d8rt_pkg::COUNT_RST;
      end
      else if (i_ce && wr_cnt)
      begin
        preload_ff <= wreq_ff.data[CW-1:0];
      end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
      begin
        cnt_ff <= d8rt_pkg::COUNT_RST;
      end
      else if (i_ce)
      begin
        if (wr_cnt && !ctl_ff.run)
        begin
          cnt_ff <= wreq_ff.data[CW-1:0];
        end
        else if (ovf[gi])
        begin
          cnt_ff <= preload_ff;
        end
        else if (tick)
        begin
          cnt_ff <= cnt_ff + 8'h01;
        end
      end
    end

    assign cnt_vec[gi*CW +: CW] = cnt_ff;
    assign ctl_vec[gi*CW +: CW] = ctl_ff;
  end

  // ==========================================================================
  // Interrupt status, enable and output
  assign clr_bits = (wr_fire && wreq_ff.mapped && wreq_ff.strb[0]
                     && wreq_ff.idx == d8rt_pkg::IDX_CLEAR)
                    ? wreq_ff.data[NT-1:0] : '0;

  // An overflow in the clearing cycle survives the clear
  // Sticky, set wins
  assign nxt_status = (status_ff & ~(clr_bits | i_irq_ack)) | ovf;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      status_ff <= d8rt_pkg::IRQ_RST;
    end
    else if (i_ce)
    begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      enable_ff <= d8rt_pkg::IRQ_RST;
    end
    else if (i_ce && wr_fire && wreq_ff.mapped && wreq_ff.strb[0]
             && wreq_ff.idx == d8rt_pkg::IDX_ENABLE)
    begin
      enable_ff <= wreq_ff.data[NT-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      irq_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      irq_ff <= |(nxt_status & enable_ff);
    end
  end

  // ==========================================================================
  // Outputs
  assign o_s_axi_awready = awready_ff;
  assign o_s_axi_wready  = wready_ff;
  assign o_s_axi_bvalid  = bvalid_ff;
  assign o_s_axi_bresp   = bresp_ff;
  assign o_s_axi_arready = arready_ff;
  assign o_s_axi_rvalid  = rvalid_ff;
  assign o_s_axi_rresp   = rresp_ff;
  assign o_s_axi_rdata   = rdata_ff;
  assign o_irq           = irq_ff;

endmodule // d8rt_top

`default_nettype wire

//--- verification/d8rt_checker.sv
`timescale 1ns/1ns
`default_nettype none
module d8rt_checker #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic                            i_clk,
  input wire logic                            i_resetn,
  input wire logic                            i_ce,
  input wire logic [ADDR_W-1:0]               i_s_axi_awaddr,
  input wire logic                            i_s_axi_awvalid,
  input wire logic                            o_s_axi_awready,
  input wire logic                            i_s_axi_wvalid,
  input wire logic                            o_s_axi_wready,
  input wire logic [1:0]                      o_s_axi_bresp,
  input wire logic                            o_s_axi_bvalid,
  input wire logic                            i_s_axi_bready,
  input wire logic [ADDR_W-1:0]               i_s_axi_araddr,
  input wire logic                            i_s_axi_arvalid,
  input wire logic                            o_s_axi_arready,
  input wire logic [31:0]                     o_s_axi_rdata,
  input wire logic [1:0]                      o_s_axi_rresp,
  input wire logic                            o_s_axi_rvalid,
  input wire logic                            i_s_axi_rready,
  input wire logic                            o_irq
);
  logic ar_t;
  logic wr_t;
  assign ar_t = i_s_axi_arvalid & o_s_axi_arready & i_ce;
  assign wr_t = i_s_axi_awvalid & o_s_axi_awready & i_s_axi_wvalid & o_s_axi_wready & i_ce;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ==========================================================================
  // Bus timing
  property p_rd_lat; ar_t |=> o_s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold;
    o_s_axi_rvalid && !(i_s_axi_rready && i_ce) |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rd_busy; o_s_axi_rvalid |-> !o_s_axi_arready; endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("second read taken");
  property p_rd_bad;
    ar_t && ((i_s_axi_araddr[ADDR_W-1:5] != '0) || (i_s_axi_araddr[4:2] == 3'h7))
      |=> o_s_axi_rresp == d8rt_pkg::RESP_SLVERR && o_s_axi_rdata == 32'h0;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped read answer");
  property p_rd_width;
    ar_t && (i_s_axi_araddr[ADDR_W-1:5] == '0) && (i_s_axi_araddr[4:2] != 3'h7)
      |=> o_s_axi_rresp == d8rt_pkg::RESP_OKAY && o_s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_width: assert property (p_rd_width) else $error("read word too wide");
  property p_wr_lat; wr_t ##1 i_ce |=> o_s_axi_bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_wr_hold;
    o_s_axi_bvalid && !(i_s_axi_bready && i_ce) |=> o_s_axi_bvalid && $stable(o_s_axi_bresp);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer moved");
  property p_wr_busy; o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("second write taken");
  property p_freeze; !i_ce |=> $stable(o_irq) && $stable(o_s_axi_rvalid); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");
  c_wr: cover property (wr_t);
  c_rd: cover property (ar_t);
  c_irq: cover property ($rose(o_irq));
endmodule // d8rt_checker
bind d8rt_top d8rt_checker #(.ADDR_W(ADDR_W)) d8rt_checker_inst (.*);
`default_nettype wire

//--- verification/d8rt_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module d8rt_top_tb_top;
  logic        i_clk, i_resetn, i_ce, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
  logic        i_s_axi_arvalid, i_s_axi_rready, o_s_axi_awready, o_s_axi_wready;
  logic        o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_irq;
  logic [7:0]  i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rd, c;
  logic [3:0]  i_s_axi_wstrb;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, i_irq_ack, rs;
  int          fail_count, tests_run, cyc, k;
  localparam logic [7:0] CNT0 = 8'h00, CNT1 = 8'h04, CTL0 = 8'h08, CTL1 = 8'h0c;
  localparam logic [7:0] STAT = 8'h10, CLR = 8'h14, ENA = 8'h18;
  d8rt_top d8rt_top_inst (.i_clk, .i_resetn, .i_ce, .i_s_axi_awaddr, .i_s_axi_awvalid,
    .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
    .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
    .i_irq_ack, .o_irq);
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================================
  // Bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(posedge i_clk);
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      if (o_s_axi_bvalid === 1'b1)
      begin
        rs = o_s_axi_bresp;
        i_s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(posedge i_clk);
      if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      if (o_s_axi_rvalid === 1'b1)
      begin
        rd = o_s_axi_rdata;
        rs = o_s_axi_rresp;
        i_s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // Hang guard, well above the expected run
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      complete_run();
    end
  end
  initial
  begin
    {i_resetn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 4'h0;
    {i_s_axi_arvalid, i_s_axi_rready, i_irq_ack} = 4'h0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = 48'h0;
    i_s_axi_wstrb = 4'hf;
    i_ce = 1'b1;
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    // ========================================================================
    // Reset values and unmapped places
    for (int k = 0; k < 7; k++)
    begin
      rdr(8'(k * 4));
      check("reset value", rd, 32'h0);
    end
    rdr(8'h1c);
    check("unmapped read", {rd[29:0], rs}, {30'h0, d8rt_pkg::RESP_SLVERR});
    wr(8'h20, 32'hff);
    check("unmapped write", {30'h0, rs}, {30'h0, d8rt_pkg::RESP_SLVERR});
    // Stopped timer takes the preload at once
    wr(CNT1, 32'h5a);
    check("write okay", {30'h0, rs}, {30'h0, d8rt_pkg::RESP_OKAY});
    // Byte lane zero off: write answered but ignored
    i_s_axi_wstrb <= 4'he;
    wr(CNT1, 32'h33);
    i_s_axi_wstrb <= 4'hf;
    rdr(CNT1);
    check("stopped load", rd, 32'h5a);
    // ========================================================================
    // Five ticks of fsys/4 over two to n, for every select value
    for (int n = 0; n < 8; n++)
    begin
      wr(CNT1, 32'h0);
      wr(CTL1, 32'h50 | n);
      repeat (20 << n) @(posedge i_clk);
      wr(CTL1, 32'h40 | n);
      rdr(CTL1);
      check("ctrl readback", rd, 32'h40 | n);
      rdr(CNT1);
      c = rd;
      check("ticks per select", {31'h0, c >= 4 && c <= 6}, 32'h1);
      repeat (50) @(posedge i_clk);
      rdr(CNT1);
      check("stopped holds", rd, c);
    end
    // ========================================================================
    // Running preload write, overflow reload, masked and sticky request
    wr(CNT0, 32'hff);
    wr(CTL0, 32'h57);
    wr(CNT0, 32'h80);
    rdr(CNT0);
    check("running load", rd, 32'hff);
    repeat (600) @(posedge i_clk);
    rdr(CNT0);
    check("reload", rd, 32'h80);
    rdr(STAT);
    check("overflow flag", rd, 32'h1);
    check("masked irq", {31'h0, o_irq}, 32'h0);
    wr(ENA, 32'h1);
    repeat (3) @(posedge i_clk);
    check("enabled irq", {31'h0, o_irq}, 32'h1);
    repeat (50) @(posedge i_clk);
    rdr(STAT);
    check("flag sticky", rd, 32'h1);
    @(posedge i_clk);
    i_irq_ack <= 2'h1;
    @(posedge i_clk);
    i_irq_ack <= 2'h0;
    repeat (3) @(posedge i_clk);
    check("ack irq", {31'h0, o_irq}, 32'h0);
    wr(CTL0, 32'h47);
    // Timer one overflow cleared by software
    wr(CNT1, 32'hfe);
    wr(ENA, 32'h2);
    wr(CTL1, 32'h50);
    repeat (30) @(posedge i_clk);
    wr(CTL1, 32'h40);
    check("irq one", {31'h0, o_irq}, 32'h1);
    rdr(STAT);
    check("flag one", rd, 32'h2);
    wr(CLR, 32'h2);
    repeat (3) @(posedge i_clk);
    rdr(STAT);
    check("cleared", {rd[30:0], o_irq}, 32'h0);
    rdr(CLR);
    check("clear reads zero", rd, 32'h0);
    // ========================================================================
    // Zero preload gives 256 ticks per overflow; enable low stretches it
    wr(ENA, 32'h1);
    wr(CNT0, 32'h0);
    wr(CTL0, 32'h50);
    for (int p = 0; p < 2; p++)
    begin
      while (o_irq !== 1'b1) @(posedge i_clk);
      i_irq_ack <= 2'h1;
      @(posedge i_clk);
      i_irq_ack <= 2'h0;
      k = 1;
      do
      begin
        @(posedge i_clk);
        k++;
        i_ce <= !(p == 1 && k > 100 && k <= 140);
      end
      while (o_irq !== 1'b1);
      check("overflow interval", k, 32'd1024 + 32'(p * 40));
    end
    wr(CTL0, 32'h40);
    complete_run();
  end
endmodule // d8rt_top_tb_top
`default_nettype wire
